// ==== core/sswd_consts.vh ====
// constants and summary of operation for the supply supervisor
// Summary of operation
// [RULE1] hold reset while supply low, release after 200ms
// [RULE2] brownout during hold restarts full hold
// [RULE3] reset pulses 200ms, low while supply low
// [RULE4] minimum hold 140ms debounces manual reset
// [RULE5] high reset is exact inverse of low
// [RULE6] timeout low after 1.6s without strobe edge
// [RULE7] timeout stays low until next strobe edge
// [RULE8] counter clears on reset, float, or edge
// [RULE9] floating strobe holds watchdog cleared, disabled
// [RULE10] strobe edge after reset starts 1.6s countdown
// [RULE11] each strobe edge restarts full countdown
// [RULE12] timeout low while supply low, no delay
// [RULE13] timeout never asserts reset by itself
// [RULE14] power fail low while aux below reference
// [RULE15] parameter selects reset polarity and watchdog variant; VARIANT only enables the watchdog, both reset outputs are always driven
// [RULE16] processor toggles strobe often enough
// [RULE17] manual reset low holds reset, hold on release
// [RULE18] inputs synchronized, periods from cycle counts
`ifndef SSWD_CONSTS_VH
`define SSWD_CONSTS_VH
`define SSWD_CLK_HZ 100000000
`define SSWD_HOLD_MS 200
`define SSWD_HOLD_MIN_MS 140
`define SSWD_WD_MS 1600
`define SSWD_HOLD_CYC ((`SSWD_CLK_HZ / 1000) * `SSWD_HOLD_MS)
`define SSWD_WD_CYC ((`SSWD_CLK_HZ / 1000) * `SSWD_WD_MS)
`define SSWD_VAR_DUAL 2'h0
`define SSWD_VAR_HIGH_WD 2'h1
`define SSWD_VAR_LOW_WD 2'h2
`define SSWD_SYNC_INIT 4'h2
`define SSWD_FLOAT_IDLE 1'h1
`define SSWD_BIT_SUPPLY 3
`define SSWD_BIT_AUX 2
`define SSWD_BIT_MR 1
`define SSWD_BIT_STROBE 0
`endif

// ==== core/sswd_sync.v ====
// two-stage synchronizer, one per bit
`timescale 1ns/10ps
module sswd_sync #(
  parameter W = 4,
  parameter [W-1:0] INIT = {W{1'b0}}
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  genvar i;
  generate
    for (i = 0; i < W; i = i + 1) begin : g_bit
      always @(posedge clk) begin
        if (rst) begin
          s1_r[i] <= INIT[i];
          s2_r[i] <= INIT[i];
        end else if (ce) begin
          s1_r[i] <= d[i];
          s2_r[i] <= s1_r[i];
        end
      end
    end
  endgenerate
  assign q = s2_r;
endmodule

// ==== core/sswd_top.v ====
// supply supervisor: reset stretcher, watchdog, power-fail flag
`timescale 1ns/10ps
`include "sswd_consts.vh"
module sswd_top #(
  parameter [1:0] VARIANT = `SSWD_VAR_LOW_WD,
  parameter HOLD_CYC = `SSWD_HOLD_CYC,
  parameter WD_CYC = `SSWD_WD_CYC,
  parameter CW = 28
) (
  // clock, reset, enable
  input wire CORE_CLK,
  input wire RST,
  input wire CE,
  // comparator and pin inputs
  input wire SUPPLY_LOW,
  input wire AUX_MONITOR_IN,
  input wire MANUAL_RESET_N,
  input wire WATCHDOG_STROBE_IN,
  input wire STROBE_FLOAT,
  // outputs
  output reg RESET_N,
  output reg RESET_HI,
  output reg WATCHDOG_TIMEOUT_N,
  output reg POWER_FAIL_N
);
  // state codes of the reset hold machine
  localparam ST_HOLD = 1'h0;
  localparam ST_RUN = 1'h1;

  // one synchronizer bit per pin, with idle levels
  localparam SYNC_W = 4;
  localparam [SYNC_W-1:0] SYNC_INIT = `SSWD_SYNC_INIT;
  localparam FLOAT_IDLE = `SSWD_FLOAT_IDLE;

  // synchronized pins
  wire [SYNC_W-1:0] sync_d;
  wire [SYNC_W-1:0] sync_q;
  wire supply_low;
  wire aux_low;
  wire mr_n;
  wire strobe;

  // float indication
  reg float_s1_r;
  reg float_s1_nxt;
  reg float_r;
  reg float_nxt;

  // strobe edge detector
  reg strobe_d_r;
  reg strobe_d_nxt;
  wire strobe_diff;
  wire edge_seen;

  // reset hold machine
  reg state_r;
  reg state_nxt;
  reg [CW-1:0] hold_cnt_r;
  reg [CW-1:0] hold_cnt_nxt;
  wire [CW-1:0] hold_last;
  wire hold_req;
  wire hold_done;
  reg rst_act;

  // watchdog
  reg [CW-1:0] wd_cnt_r;
  reg [CW-1:0] wd_cnt_nxt;
  reg wd_run_r;
  reg wd_run_nxt;
  reg wd_exp_r;
  reg wd_exp_nxt;
  wire [CW-1:0] wd_last;
  wire has_wd;
  wire wd_clear;
  wire wd_done;
  wire wdo_low;

  // output next values
  reg reset_n_nxt;
  reg reset_hi_nxt;
  reg wdo_n_nxt;
  reg pf_n_nxt;

  // pins into the synchronizer, idle levels preset [RULE18]
  assign sync_d = {SUPPLY_LOW, AUX_MONITOR_IN, MANUAL_RESET_N, WATCHDOG_STROBE_IN};

  sswd_sync #(.W(SYNC_W), .INIT(SYNC_INIT)) u_sync (
    .clk(CORE_CLK),
    .rst(RST),
    .ce(CE),
    .d(sync_d),
    .q(sync_q)
  );

  // synchronized pin fields
  assign supply_low = sync_q[`SSWD_BIT_SUPPLY];
  assign aux_low = sync_q[`SSWD_BIT_AUX];
  assign mr_n = sync_q[`SSWD_BIT_MR];
  assign strobe = sync_q[`SSWD_BIT_STROBE];

  // variant decode [RULE15]
  assign has_wd = (VARIANT != `SSWD_VAR_DUAL);

  // edge of either polarity while driven [RULE8]
  assign strobe_diff = strobe ^ strobe_d_r;
  assign edge_seen = strobe_diff && !float_r;

  // hold request and terminal count
  assign hold_req = supply_low || !mr_n;
  assign hold_last = HOLD_CYC[CW-1:0] - 1'h1;
  assign hold_done = (hold_cnt_r >= hold_last);

  // watchdog clear and terminal count
  assign wd_clear = !has_wd || rst_act || float_r;
  assign wd_last = WD_CYC[CW-1:0] - 1'h1;
  assign wd_done = (wd_cnt_r >= wd_last);

  // timeout low on supply fault or expiry
  assign wdo_low = has_wd && (supply_low || wd_exp_r);

  // next-value logic

  // float and edge detector next values
  always @* begin
    float_s1_nxt = STROBE_FLOAT;
    float_nxt = float_s1_r;
    strobe_d_nxt = strobe;
  end

  // reset hold next state
  always @* begin
    state_nxt = state_r;
    hold_cnt_nxt = hold_cnt_r;
    case (state_r)
      ST_HOLD: begin
        if (hold_req) begin
          hold_cnt_nxt = {CW{1'h0}}; // [RULE1] [RULE2] [RULE17] [RULE4]
        end else if (hold_done) begin
          state_nxt = ST_RUN; // [RULE1] [RULE3]
        end else begin
          hold_cnt_nxt = hold_cnt_r + 1'h1;
        end
      end
      ST_RUN: begin
        hold_cnt_nxt = {CW{1'h0}};
        if (hold_req) begin
          state_nxt = ST_HOLD; // [RULE3] [RULE17]
        end
      end
      default: begin
        state_nxt = ST_HOLD;
        hold_cnt_nxt = {CW{1'h0}};
      end
    endcase
  end

  // reset active while holding or a request stands
  always @* begin
    rst_act = (state_r == ST_HOLD) || hold_req;
  end

  // watchdog next values; timeout does not feed reset [RULE13]
  always @* begin
    wd_cnt_nxt = wd_cnt_r;
    wd_run_nxt = wd_run_r;
    wd_exp_nxt = wd_exp_r;
    if (wd_clear) begin
      wd_cnt_nxt = {CW{1'h0}}; // [RULE8] [RULE9]
      wd_run_nxt = 1'h0;
      wd_exp_nxt = 1'h0;
    end else if (edge_seen) begin
      wd_cnt_nxt = {CW{1'h0}}; // [RULE10] [RULE11] [RULE8]
      wd_run_nxt = 1'h1;
      wd_exp_nxt = 1'h0; // [RULE7]
    end else if (wd_run_r) begin
      if (wd_done) begin
        wd_run_nxt = 1'h0;
        wd_exp_nxt = 1'h1; // [RULE6]
      end else begin
        wd_cnt_nxt = wd_cnt_r + 1'h1;
      end
    end
  end

  // output next values
  always @* begin
    reset_n_nxt = !rst_act; // [RULE3]
    reset_hi_nxt = rst_act; // [RULE5]
    wdo_n_nxt = !wdo_low; // [RULE12] [RULE6] [RULE7]
    pf_n_nxt = !aux_low; // [RULE14]
  end

  // registers, all frozen while CE is low

  // float synchronizer, first stage
  always @(posedge CORE_CLK) begin
    if (RST) begin
      float_s1_r <= FLOAT_IDLE;
    end else if (CE) begin
      float_s1_r <= float_s1_nxt;
    end
  end

  // float synchronizer, second stage
  always @(posedge CORE_CLK) begin
    if (RST) begin
      float_r <= FLOAT_IDLE;
    end else if (CE) begin
      float_r <= float_nxt;
    end
  end

  // strobe delay, idle matches synchronizer
  always @(posedge CORE_CLK) begin
    if (RST) begin
      strobe_d_r <= SYNC_INIT[`SSWD_BIT_STROBE];
    end else if (CE) begin
      strobe_d_r <= strobe_d_nxt;
    end
  end

  // hold state
  always @(posedge CORE_CLK) begin
    if (RST) begin
      state_r <= ST_HOLD;
    end else if (CE) begin
      state_r <= state_nxt;
    end
  end

  // hold counter
  always @(posedge CORE_CLK) begin
    if (RST) begin
      hold_cnt_r <= {CW{1'h0}};
    end else if (CE) begin
      hold_cnt_r <= hold_cnt_nxt;
    end
  end

  // watchdog counter
  always @(posedge CORE_CLK) begin
    if (RST) begin
      wd_cnt_r <= {CW{1'h0}};
    end else if (CE) begin
      wd_cnt_r <= wd_cnt_nxt;
    end
  end

  // watchdog running flag
  always @(posedge CORE_CLK) begin
    if (RST) begin
      wd_run_r <= 1'h0;
    end else if (CE) begin
      wd_run_r <= wd_run_nxt;
    end
  end

  // watchdog expired flag
  always @(posedge CORE_CLK) begin
    if (RST) begin
      wd_exp_r <= 1'h0;
    end else if (CE) begin
      wd_exp_r <= wd_exp_nxt;
    end
  end

  // outputs straight from flops

  // active-low reset
  always @(posedge CORE_CLK) begin
    if (RST) begin
      RESET_N <= 1'h0;
    end else if (CE) begin
      RESET_N <= reset_n_nxt;
    end
  end

  // active-high reset
  always @(posedge CORE_CLK) begin
    if (RST) begin
      RESET_HI <= 1'h1;
    end else if (CE) begin
      RESET_HI <= reset_hi_nxt;
    end
  end

  // watchdog timeout
  always @(posedge CORE_CLK) begin
    if (RST) begin
      WATCHDOG_TIMEOUT_N <= 1'h1;
    end else if (CE) begin
      WATCHDOG_TIMEOUT_N <= wdo_n_nxt;
    end
  end

  // power fail
  always @(posedge CORE_CLK) begin
    if (RST) begin
      POWER_FAIL_N <= 1'h1;
    end else if (CE) begin
      POWER_FAIL_N <= pf_n_nxt;
    end
  end
endmodule

// ==== test/sswd_checker.sv ====
// port assertions for the supply supervisor
`timescale 1ns/10ps
module sswd_checker #(parameter HOLD_CYC = 50, parameter WD_CYC = 200) (
  // inputs
  input wire CORE_CLK,
  input wire RST,
  input wire SUPPLY_LOW,
  input wire AUX_MONITOR_IN,
  input wire MANUAL_RESET_N,
  input wire WATCHDOG_STROBE_IN,
  // outputs
  input wire RESET_N,
  input wire RESET_HI,
  input wire WATCHDOG_TIMEOUT_N,
  input wire POWER_FAIL_N
);
  int q_r = 0;
  int s_r = 0;
  logic w_r = 1'b0;
  always @(posedge CORE_CLK) begin
    q_r <= (RST || SUPPLY_LOW || !MANUAL_RESET_N) ? 0 : q_r + 1;
    w_r <= WATCHDOG_STROBE_IN;
    s_r <= (WATCHDOG_STROBE_IN != w_r) ? 0 : s_r + 1;
  end
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  a_hi_inverse: assert property (RESET_HI == !RESET_N) else $error("bad hi");
  a_supply_hold: assert property ($rose(SUPPLY_LOW) |-> ##3 !RESET_N &&
    !WATCHDOG_TIMEOUT_N) else $error("no reset");
  a_hold_len: assert property ($rose(RESET_N) |-> q_r >= HOLD_CYC &&
    q_r <= HOLD_CYC + 6) else $error("bad hold");
  a_wdo_back: assert property ($fell(SUPPLY_LOW) |-> ##3 WATCHDOG_TIMEOUT_N)
    else $error("wdo late");
  a_mr_assert: assert property ($fell(MANUAL_RESET_N) |-> ##3 !RESET_N)
    else $error("mr ignored");
  a_pf_follow: assert property (POWER_FAIL_N == !$past(AUX_MONITOR_IN, 3))
    else $error("bad pf");
  a_wd_bite: assert property ($fell(WATCHDOG_TIMEOUT_N) && RESET_N |->
    (s_r >= WD_CYC && s_r <= WD_CYC + 6) ##1 RESET_N) else $error("bad bite");
  a_wdo_sticky: assert property ($rose(WATCHDOG_TIMEOUT_N) |-> s_r < 6 ||
    $past(SUPPLY_LOW, 4)) else $error("wdo rose");
endmodule
bind sswd_top sswd_checker #(.HOLD_CYC(HOLD_CYC), .WD_CYC(WD_CYC)) chk (.CORE_CLK(CORE_CLK),
  .RST(RST), .SUPPLY_LOW(SUPPLY_LOW), .AUX_MONITOR_IN(AUX_MONITOR_IN),
  .MANUAL_RESET_N(MANUAL_RESET_N), .WATCHDOG_STROBE_IN(WATCHDOG_STROBE_IN),
  .RESET_N(RESET_N), .RESET_HI(RESET_HI), .WATCHDOG_TIMEOUT_N(WATCHDOG_TIMEOUT_N),
  .POWER_FAIL_N(POWER_FAIL_N));

// ==== test/sswd_cpu.sv ====
// processor model that toggles the watchdog strobe
`timescale 1ns/10ps
module sswd_cpu #(parameter PER = 30) (
  // control
  input wire clk,
  input wire en,
  // strobe line
  output logic watchdog_strobe_in
);
  int n_r = 0;
  initial watchdog_strobe_in = 1'h0;
  always @(posedge clk) begin
    n_r <= (n_r == PER - 1) ? 0 : n_r + 1;
    if (en && n_r == 0) begin
      watchdog_strobe_in <= #1 !watchdog_strobe_in;
    end
  end
endmodule

// ==== test/testbench.sv ====
// self-checking bench for the supply supervisor
`timescale 1ns/10ps
module testbench;
  localparam int HC = 50;
  localparam int WC = 200;
  logic clk = 1'h0;
  logic rst = 1'h1;
  logic sup = 1'h0;
  logic aux = 1'h0;
  logic mrn = 1'h1;
  logic flt = 1'h0;
  logic en = 1'h1;
  wire watchdog_strobe_in, rn, rh, watchdog_timeout_n, pfn;
  int failures = 0;
  int n_tests = 0;
  // supply, aux, manual reset, expected reset_n, expected power_fail_n
  logic [4:0] rows [4] = '{5'h07, 5'h0E, 5'h15, 5'h01};
  sswd_cpu cpu (.clk(clk), .en(en), .watchdog_strobe_in(watchdog_strobe_in));
  sswd_top #(.HOLD_CYC(HC), .WD_CYC(WC)) uut (.CORE_CLK(clk), .RST(rst), .CE(1'h1),
    .SUPPLY_LOW(sup), .AUX_MONITOR_IN(aux), .MANUAL_RESET_N(mrn), .WATCHDOG_STROBE_IN(watchdog_strobe_in),
    .STROBE_FLOAT(flt), .RESET_N(rn), .RESET_HI(rh), .WATCHDOG_TIMEOUT_N(watchdog_timeout_n),
    .POWER_FAIL_N(pfn));
  initial begin
    forever #5 clk = !clk;
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task chk(input string nm, input logic e, input logic s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("ERROR %s exp %b got %b", nm, e, s);
    end
  endtask
  task stop_test;
    $display("checks %0d errors %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    tick(2);
    rst = 1'h0;
    foreach (rows[i]) begin
      {sup, aux, mrn} = rows[i][4:2];
      tick(HC + 10);
      chk("reset_n", rows[i][1], rn);
      chk("reset_hi", !rows[i][1], rh);
      chk("power_fail_n", rows[i][0], pfn);
    end
    mrn = 1'h1;
    tick(HC + 10);
    sup = 1'h1;
    tick(5);
    sup = 1'h0;
    tick(HC / 2);
    sup = 1'h1;
    tick(3);
    sup = 1'h0;
    tick(4);
    chk("wdo_back", 1'h1, watchdog_timeout_n);
    tick(HC - 9);
    chk("rst_ext", 1'h0, rn);
    tick(13);
    chk("rst_rel", 1'h1, rn);
    tick(40);
    en = 1'h0;
    tick(WC - 32);
    chk("wdo_early", 1'h1, watchdog_timeout_n);
    tick(42);
    chk("wdo_bite", 1'h0, watchdog_timeout_n);
    chk("no_self_rst", 1'h1, rn);
    en = 1'h1;
    tick(40);
    chk("wdo_clear", 1'h1, watchdog_timeout_n);
    flt = 1'h1;
    en = 1'h0;
    tick(WC + 20);
    chk("wdo_float", 1'h1, watchdog_timeout_n);
    stop_test();
  end
endmodule
